/* File: hw/afbp_pkg.sv */
// shared constants and types for the async fifo / bit-bang port
package afbp_pkg;

  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;

  // clock: 200 MHz
  localparam int CLK_PERIOD_PS = 5000;

  // bit-bang strobe low time, least value
  localparam int BB_STROBE_NS = 50;
  localparam int BB_STROBE_CYC = (BB_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] BB_STROBE_CNT = CNT_W'(BB_STROBE_CYC - 1);

  // reset values of pin-side signals
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic FLAG_INACTIVE = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [1:0] {
    AFBP_MODE_OFF,
    AFBP_MODE_FIFO,
    AFBP_MODE_BB_ASYNC,
    AFBP_MODE_BB_SYNC
  } afbp_mode_e;

  typedef enum logic [1:0] {
    AFBP_ST_IDLE,
    AFBP_ST_WRITE,
    AFBP_ST_SAMPLE,
    AFBP_ST_SEND
  } afbp_state_e;

endpackage : afbp_pkg

/* File: hw/afbp_port.sv */
// async fifo / bit-bang parallel port channel with its receive fifo
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// receive fifo
module afbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] s_data,
  input wire logic s_valid,
  output logic s_ready,
  output logic [WIDTH-1:0] m_data,
  output logic m_valid,
  input wire logic m_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } afbp_fifo_s;

  afbp_fifo_s r;
  afbp_fifo_s next_r;
  logic full;
  logic empty;

  assign empty = (r.wp == r.rp);
  assign full = (r.wp[AW-1:0] == r.rp[AW-1:0]) && (r.wp[AW] != r.rp[AW]);
  assign s_ready = ~full;
  assign m_valid = ~empty;
  assign m_data = r.mem[r.rp[AW-1:0]];

  always_comb begin
    next_r = r;
    if (s_valid && !full) begin
      next_r.mem[r.wp[AW-1:0]] = s_data;
      next_r.wp = r.wp + 1'b1;
    end
    if (m_ready && !empty) begin
      next_r.rp = r.rp + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : afbp_fifo

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - fifo mode moves bytes on falling read and write strobes, no interface clock.
// - in fifo mode data lines stay inputs except while the read strobe is low.
// - receive flag low while a byte waits, high otherwise; no reads while high.
// - each read strobe rise forces receive flag high; low again only if more data.
// - during reset both flag outputs are released, pulled up outside.
// - transmit flag low when a byte fits; writer pulses strobe only while low.
// - read fall drives current byte; read rise advances to the next byte.
// - a write strobe fall captures the data lines into the transmit path unless the holding word is full.
// - suspended with wakeup enabled, a send/wakeup low pulse requests bus resume.
// - powered, a send/wakeup low pulse flushes pending transmit data next bulk-in.
// - fifo mode is chosen per channel from nonvolatile configuration.
// - bit-bang turns the eight lines into a bidirectional port, sync or async.
// - bit-bang pulses write indicator low when new host data sits on the lines.
// - bit-bang pulses read indicator low when the lines are sampled into the transmit path.
module afbp_port (
  input wire logic mclk,
  input wire logic reset_n,
  input afbp_pkg::afbp_mode_e cfg_mode,
  input wire logic cfg_wakeup_en,
  input wire logic [afbp_pkg::DATA_W-1:0] cfg_bb_dir,
  input wire logic usb_suspended,
  input wire logic [afbp_pkg::DATA_W-1:0] usb_rx_data,
  input wire logic usb_rx_valid,
  output logic usb_rx_ready,
  output logic [afbp_pkg::DATA_W-1:0] usb_tx_data,
  output logic usb_tx_valid,
  input wire logic usb_tx_ready,
  output logic send_now_req,
  output logic resume_req,
  output logic power_on_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic send_now_wakeup_n,
  input wire logic [afbp_pkg::DATA_W-1:0] data_in,
  output logic [afbp_pkg::DATA_W-1:0] data_out,
  output logic [afbp_pkg::DATA_W-1:0] data_oe,
  output logic rx_avail_n,
  output logic tx_space_n,
  output logic flags_oe,
  output logic bb_write_pulse_n,
  output logic bb_read_pulse_n
);
  import afbp_pkg::*;

  typedef struct packed {
    logic rd_s1;
    logic rd_s2;
    logic rd_q;
    logic wr_s1;
    logic wr_s2;
    logic wr_q;
    logic sw_s1;
    logic sw_s2;
    logic sw_q;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;
    afbp_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] oe;
    logic rx_flag_n;
    logic tx_flag_n;
    logic flags_on;
    logic tx_full;
    logic [DATA_W-1:0] tx_data;
    logic wstb_n;
    logic rstb_n;
    logic send_now;
    logic resume;
    logic pwr_n;
  } afbp_port_s;

  localparam afbp_port_s RST = '{
    rd_s1: STROBE_IDLE, rd_s2: STROBE_IDLE, rd_q: STROBE_IDLE,
    wr_s1: STROBE_IDLE, wr_s2: STROBE_IDLE, wr_q: STROBE_IDLE,
    sw_s1: STROBE_IDLE, sw_s2: STROBE_IDLE, sw_q: STROBE_IDLE,
    din_s1: DATA_RST, din_s2: DATA_RST,
    st: AFBP_ST_IDLE, cnt: '0,
    dout: DATA_RST, oe: '0,
    rx_flag_n: FLAG_INACTIVE, tx_flag_n: FLAG_INACTIVE, flags_on: 1'b0,
    tx_full: 1'b0, tx_data: DATA_RST,
    wstb_n: STROBE_IDLE, rstb_n: STROBE_IDLE,
    send_now: 1'b0, resume: 1'b0, pwr_n: 1'b1
  };

  afbp_port_s r;
  afbp_port_s next_r;

  logic [DATA_W-1:0] rx_head;
  logic rx_valid;
  logic rx_pop;
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic sw_fall;
  logic is_fifo;
  logic is_bb;
  logic cnt_done;

  //////////////////////////////////////////////////////////////////////////////
  // receive buffer, usb side stalls on full
  afbp_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .s_data(usb_rx_data),
    .s_valid(usb_rx_valid),
    .s_ready(usb_rx_ready),
    .m_data(rx_head),
    .m_valid(rx_valid),
    .m_ready(rx_pop)
  );

  //////////////////////////////////////////////////////////////////////////////
  // edge detect on synchronised strobes
  assign rd_fall = r.rd_q & ~r.rd_s2;
  assign rd_rise = ~r.rd_q & r.rd_s2;
  assign wr_fall = r.wr_q & ~r.wr_s2;
  assign sw_fall = r.sw_q & ~r.sw_s2;
  assign is_fifo = (cfg_mode == AFBP_MODE_FIFO);
  assign is_bb = (cfg_mode == AFBP_MODE_BB_ASYNC) || (cfg_mode == AFBP_MODE_BB_SYNC);
  assign cnt_done = (r.cnt == '0);

  // pop: fifo mode on read rise, bit-bang when a byte goes to the lines
  always_comb begin
    rx_pop = 1'b0;
    if (is_fifo) begin
      rx_pop = rd_rise & ~r.rx_flag_n & rx_valid;
    end else if (cfg_mode == AFBP_MODE_BB_ASYNC) begin
      rx_pop = (r.st == AFBP_ST_IDLE) & rx_valid & ~r.tx_full;
    end else if (cfg_mode == AFBP_MODE_BB_SYNC) begin
      rx_pop = (r.st == AFBP_ST_SEND) & cnt_done & rx_valid;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_r = r;
    next_r.rd_s1 = rd_n;
    next_r.rd_s2 = r.rd_s1;
    next_r.rd_q = r.rd_s2;
    next_r.wr_s1 = wr_n;
    next_r.wr_s2 = r.wr_s1;
    next_r.wr_q = r.wr_s2;
    next_r.sw_s1 = send_now_wakeup_n;
    next_r.sw_s2 = r.sw_s1;
    next_r.sw_q = r.sw_s2;
    next_r.din_s1 = data_in;
    next_r.din_s2 = r.din_s1;
    next_r.flags_on = 1'b1;
    next_r.send_now = 1'b0;
    next_r.resume = 1'b0;
    next_r.pwr_n = usb_suspended;
    if (!cnt_done) begin
      next_r.cnt = r.cnt - 1'b1;
    end

    // transmit holding word drains to usb
    if (r.tx_full && usb_tx_ready) begin
      next_r.tx_full = 1'b0;
    end

    // send immediate / wakeup
    if (sw_fall) begin
      if (r.pwr_n && cfg_wakeup_en) begin
        next_r.resume = 1'b1;
      end else if (!r.pwr_n) begin
        next_r.send_now = 1'b1;
      end
    end

    if (is_fifo) begin
      next_r.st = AFBP_ST_IDLE;
      next_r.wstb_n = STROBE_IDLE;
      next_r.rstb_n = STROBE_IDLE;
      // read side
      if (rd_fall) begin
        next_r.dout = rx_head;
        next_r.oe = '1;
      end
      if (r.rd_s2) begin
        next_r.oe = '0;
      end
      if (rd_rise) begin
        next_r.rx_flag_n = 1'b1;
      end else if (r.rd_s2) begin
        next_r.rx_flag_n = ~rx_valid;
      end
      // write side, full holding word ignores the strobe
      if (wr_fall && !r.tx_full) begin
        next_r.tx_data = r.din_s2;
        next_r.tx_full = 1'b1;
      end
      next_r.tx_flag_n = next_r.tx_full;
    end else if (is_bb) begin
      next_r.oe = cfg_bb_dir;
      next_r.rx_flag_n = FLAG_INACTIVE;
      next_r.tx_flag_n = FLAG_INACTIVE;
      case (r.st)
        AFBP_ST_IDLE: begin
          if (cfg_mode == AFBP_MODE_BB_ASYNC) begin
            if (rx_valid && !r.tx_full) begin
              next_r.dout = rx_head;
              next_r.wstb_n = 1'b0;
              next_r.cnt = BB_STROBE_CNT;
              next_r.st = AFBP_ST_WRITE;
            end
          end else if (rx_valid && !r.tx_full) begin
            next_r.st = AFBP_ST_SAMPLE;
          end
        end
        AFBP_ST_WRITE: begin
          if (cnt_done) begin
            next_r.wstb_n = STROBE_IDLE;
            // async samples after writing, sync has sampled already
            if (cfg_mode == AFBP_MODE_BB_ASYNC) begin
              next_r.st = AFBP_ST_SAMPLE;
            end else begin
              next_r.st = AFBP_ST_IDLE;
            end
          end
        end
        AFBP_ST_SAMPLE: begin
          if (!r.tx_full) begin
            next_r.tx_data = r.din_s2;
            next_r.tx_full = 1'b1;
            next_r.rstb_n = 1'b0;
            next_r.cnt = BB_STROBE_CNT;
            next_r.st = AFBP_ST_SEND;
          end
        end
        AFBP_ST_SEND: begin
          if (cnt_done) begin
            next_r.rstb_n = STROBE_IDLE;
            if (cfg_mode == AFBP_MODE_BB_SYNC && rx_valid) begin
              next_r.dout = rx_head;
              next_r.wstb_n = 1'b0;
              next_r.cnt = BB_STROBE_CNT;
              next_r.st = AFBP_ST_WRITE;
            end else begin
              next_r.st = AFBP_ST_IDLE;
            end
          end
        end
        default: begin
          next_r.st = AFBP_ST_IDLE;
        end
      endcase
    end else begin
      next_r.st = AFBP_ST_IDLE;
      next_r.oe = '0;
      next_r.rx_flag_n = FLAG_INACTIVE;
      next_r.tx_flag_n = FLAG_INACTIVE;
      next_r.wstb_n = STROBE_IDLE;
      next_r.rstb_n = STROBE_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r <= RST;
    end else begin
      r <= next_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign data_out = r.dout;
  assign data_oe = r.oe;
  assign rx_avail_n = r.rx_flag_n;
  assign tx_space_n = r.tx_flag_n;
  assign flags_oe = r.flags_on;
  assign bb_write_pulse_n = r.wstb_n;
  assign bb_read_pulse_n = r.rstb_n;
  assign usb_tx_data = r.tx_data;
  assign usb_tx_valid = r.tx_full;
  assign send_now_req = r.send_now;
  assign resume_req = r.resume;
  assign power_on_n = r.pwr_n;
endmodule : afbp_port

/* File: hw/afbp_pkg_unused_guard.sv */
// spare design file, holds no logic

/* File: sim/afbp_port_asserts.sv */
// checker for the async fifo / bit-bang port
`timescale 1ns/1ps
module afbp_chk
  import afbp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input afbp_pkg::afbp_mode_e cfg_mode,
  input wire logic cfg_wakeup_en,
  input wire logic usb_tx_valid,
  input wire logic send_now_req,
  input wire logic resume_req,
  input wire logic power_on_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [afbp_pkg::DATA_W-1:0] data_oe,
  input wire logic rx_avail_n,
  input wire logic tx_space_n,
  input wire logic flags_oe,
  input wire logic bb_write_pulse_n
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  wire fm = cfg_mode == AFBP_MODE_FIFO;
  property p_oe; fm && data_oe != 8'h00 |-> !($past(rd_n, 2) && $past(rd_n, 3) && $past(rd_n, 4)); endproperty
  a_oe: assert property (p_oe) else $error("data driven with read idle");
  property p_rdf; fm && $fell(rd_n) |-> ##[2:4] data_oe == 8'hff; endproperty
  a_rdf: assert property (p_rdf) else $error("read fall not served");
  property p_rdr; fm && $rose(rd_n) |-> ##[2:4] rx_avail_n; endproperty
  a_rdr: assert property (p_rdr) else $error("receive flag not forced high");
  property p_wr; fm && $fell(wr_n) && !tx_space_n |-> ##[2:4] usb_tx_valid && tx_space_n; endproperty
  a_wr: assert property (p_wr) else $error("write not captured");
  property p_rst;
    @(posedge mclk) disable iff (1'b0) !reset_n && !$past(reset_n) |-> !flags_oe && rx_avail_n && tx_space_n;
  endproperty
  a_rst: assert property (p_rst) else $error("flags not released in reset");
  property p_sn; send_now_req |-> !power_on_n ##1 !send_now_req; endproperty
  a_sn: assert property (p_sn) else $error("bad send request");
  property p_rs; resume_req |-> power_on_n && cfg_wakeup_en ##1 !resume_req; endproperty
  a_rs: assert property (p_rs) else $error("bad resume request");
  property p_wp; $fell(bb_write_pulse_n) |-> (!bb_write_pulse_n) [*8]; endproperty
  a_wp: assert property (p_wp) else $error("write indicator too short");
  c_rd: cover property (fm && $fell(rd_n));
  c_sn: cover property (send_now_req);
  c_bb: cover property ($fell(bb_write_pulse_n));
endmodule : afbp_chk
bind afbp_port afbp_chk u_chk (.mclk, .reset_n, .cfg_mode, .cfg_wakeup_en, .usb_tx_valid, .send_now_req,
  .resume_req, .power_on_n, .rd_n, .wr_n, .data_oe, .rx_avail_n, .tx_space_n, .flags_oe, .bb_write_pulse_n);

/* File: sim/afbp_ext_model.sv */
// external logic on the parallel byte bus
`timescale 1ns/1ps
module afbp_ext_model
  import afbp_pkg::*;
(
  input wire logic mclk,
  input wire logic [afbp_pkg::DATA_W-1:0] data_out,
  input wire logic [afbp_pkg::DATA_W-1:0] data_oe,
  input wire logic rx_avail_n,
  input wire logic tx_space_n,
  output logic rd_n = 1'b1,
  output logic wr_n = 1'b1,
  output logic send_now_wakeup_n = 1'b1,
  output logic [afbp_pkg::DATA_W-1:0] data_in
);
  logic [DATA_W-1:0] drv = 8'h00;
  logic drv_en = 1'b0;
  // released bits show the inverse of the last value
  assign data_in = (data_oe & data_out) | (~data_oe & (drv_en ? drv : ~drv));
  task automatic drive(input logic [7:0] d);
    drv <= d;
    drv_en <= 1'b1;
  endtask : drive
  task automatic rd(output logic [7:0] d);
    for (int i = 0; i < 99 && rx_avail_n !== 1'b0; i++) @(posedge mclk);
    rd_n <= 1'b0;
    repeat (5) @(posedge mclk);
    d = data_out;
    rd_n <= 1'b1;
    repeat (5) @(posedge mclk);
  endtask : rd
  task automatic wr(input logic [7:0] d, input bit ignore_flag);
    for (int i = 0; i < 99 && !ignore_flag && tx_space_n !== 1'b0; i++) @(posedge mclk);
    drive(d);
    @(posedge mclk);
    wr_n <= 1'b0;
    repeat (5) @(posedge mclk);
    wr_n <= 1'b1;
    repeat (4) @(posedge mclk);
    drv_en <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic pulse_send_now_wakeup_n;
    send_now_wakeup_n <= 1'b0;
    repeat (4) @(posedge mclk);
    send_now_wakeup_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask : pulse_send_now_wakeup_n
endmodule : afbp_ext_model

/* File: sim/tb_afbp_port.sv */
// self-checking bench for the async fifo / bit-bang port
`timescale 1ns/1ps
module tb_afbp_port;
  import afbp_pkg::*;
  logic mclk = 1'b0, reset_n = 1'b1, cfg_wakeup_en = 1'b0, usb_suspended = 1'b0, usb_rx_valid = 1'b0;
  logic usb_tx_ready = 1'b0, usb_rx_ready, usb_tx_valid, send_now_req, resume_req, power_on_n, rd_n, wr_n;
  logic send_now_wakeup_n, rx_avail_n, tx_space_n, flags_oe, bb_write_pulse_n, bb_read_pulse_n;
  logic [7:0] cfg_bb_dir = 8'h0f, usb_rx_data = 8'h00, usb_tx_data, data_in, data_out, data_oe, got;
  afbp_mode_e cfg_mode = AFBP_MODE_FIFO;
  int bad_count = 0, checks_done = 0, sn = 0, rs = 0;
  logic [7:0] q[$];
  afbp_port DUT (.mclk, .reset_n, .cfg_mode, .cfg_wakeup_en, .cfg_bb_dir, .usb_suspended, .usb_rx_data,
    .usb_rx_valid, .usb_rx_ready, .usb_tx_data, .usb_tx_valid, .usb_tx_ready, .send_now_req, .resume_req,
    .power_on_n, .rd_n, .wr_n, .send_now_wakeup_n, .data_in, .data_out, .data_oe, .rx_avail_n, .tx_space_n,
    .flags_oe, .bb_write_pulse_n, .bb_read_pulse_n);
  afbp_ext_model m (.mclk, .data_out, .data_oe, .rx_avail_n, .tx_space_n, .rd_n, .wr_n, .send_now_wakeup_n,
    .data_in);
  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    sn += int'(send_now_req === 1'b1);
    rs += int'(resume_req === 1'b1);
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [7:0] line_value(input logic [7:0] drv, input logic [7:0] dir, input logic [7:0] ext);
    return (drv & dir) | (ext & ~dir);
  endfunction : line_value
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic do_reset(input afbp_mode_e mode);
    reset_n <= 1'b0;
    cfg_mode <= mode;
    repeat (6) @(posedge mclk);
    chk("flags", {5'h0, flags_oe, rx_avail_n, tx_space_n}, 8'h03);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask : do_reset
  task automatic push(input logic [7:0] d);
    usb_rx_data <= d;
    usb_rx_valid <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 99 && usb_rx_ready !== 1'b1; i++) @(posedge mclk);
    if (usb_rx_ready !== 1'b1) bad_count++;
  endtask : push
  task automatic drain(output logic [7:0] d);
    for (int i = 0; i < 400 && usb_tx_valid !== 1'b1; i++) @(posedge mclk);
    if (usb_tx_valid !== 1'b1) bad_count++;
    d = usb_tx_data;
    usb_tx_ready <= 1'b1;
    @(posedge mclk);
    usb_tx_ready <= 1'b0;
    @(posedge mclk);
  endtask : drain
  initial begin
    #100us;
    bad_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(80117));
    do_reset(AFBP_MODE_FIFO);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      q.push_back(8'($urandom));
      push(q[i]);
    end
    usb_rx_valid <= 1'b0;
    @(posedge mclk);
    chk("rx_ready", {7'h0, usb_rx_ready}, 8'h00);
    chk("rx_avail", {7'h0, rx_avail_n}, 8'h00);
    chk("oe_idle", data_oe, 8'h00);
    foreach (q[i]) begin
      m.rd(got);
      chk("rd_byte", got, q[i]);
    end
    chk("rx_empty", {7'h0, rx_avail_n}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      q[i] = (i < 2) ? {8{i[0]}} : 8'($urandom);
      m.wr(q[i], 1'b0);
      chk("tx_full", {7'h0, tx_space_n}, 8'h01);
      if (i == 3) m.wr(~q[i], 1'b1);
      drain(got);
      chk("wr_byte", got, q[i]);
      chk("tx_free", {7'h0, tx_space_n}, 8'h00);
    end
    for (int k = 0; k < 3; k++) begin
      usb_suspended <= (k > 0);
      cfg_wakeup_en <= (k == 1);
      repeat (3) @(posedge mclk);
      chk("power_on", {7'h0, power_on_n}, 8'(k > 0));
      sn = 0;
      rs = 0;
      m.pulse_send_now_wakeup_n();
      chk("send_now", 8'(sn), 8'(k == 0));
      chk("resume", 8'(rs), 8'(k == 1));
    end
    for (int j = 0; j < 2; j++) begin
      do_reset(j ? AFBP_MODE_BB_SYNC : AFBP_MODE_BB_ASYNC);
      q[0] = 8'($urandom);
      m.drive(~q[0]);
      push(q[0]);
      usb_rx_valid <= 1'b0;
      fork
        begin
          for (int i = 0; i < 400 && bb_write_pulse_n !== 1'b0; i++) @(posedge mclk);
          chk("bb_wr_pulse", {7'h0, bb_write_pulse_n}, 8'h00);
          chk("bb_out", data_out, q[0]);
          chk("bb_oe", data_oe, cfg_bb_dir);
        end
        begin
          for (int i = 0; i < 400 && usb_tx_valid !== 1'b1; i++) @(posedge mclk);
          chk("bb_rd_low", {7'h0, bb_read_pulse_n}, 8'h00);
          drain(got);
          chk("bb_in", got, line_value(j ? 8'h00 : q[0], cfg_bb_dir, ~q[0]));
          for (int i = 0; i < 40 && bb_read_pulse_n !== 1'b1; i++) @(posedge mclk);
          chk("bb_rd_rise", {7'h0, bb_read_pulse_n}, 8'h01);
        end
      join
    end
    do_reset(AFBP_MODE_OFF);
    push(8'($urandom));
    usb_rx_valid <= 1'b0;
    repeat (20) @(posedge mclk);
    chk("off_oe", data_oe, 8'h00);
    chk("off_pins", {4'h0, rx_avail_n, tx_space_n, bb_write_pulse_n, usb_tx_valid}, 8'h0e);
    end_of_test();
  end
endmodule : tb_afbp_port
